// File: hdl/ssfec_top.sv
// sync serial unit: format and enable control, shifter, flags and avalon slave
`timescale 1ns/100ps
`default_nettype none
module ssfec_top (
  // clock, reset, enable
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic CLK_EN_I,
  // avalon-mm slave
  input wire logic [ssfec_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [ssfec_pkg::BE_W-1:0] AVS_BYTEENABLE_I,
  input wire logic [ssfec_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
  output logic [ssfec_pkg::DATA_W-1:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // serial pins
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_N_O,
  input wire logic SDI_I,
  output logic SDO_O,
  input wire logic SUB_CLK_I,
  // interrupt requests
  output logic IRQ_O,
  output logic TX_END_IRQ_O,
  output logic TX_DATA_IRQ_O,
  output logic RX_DATA_IRQ_O,
  output logic OVERRUN_IRQ_O,
  output logic CONFLICT_IRQ_O
);
  import ssfec_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [REG_W-1:0] transfer_format_control;
  logic [REG_W-1:0] transfer_and_irq_enable;
  logic [REG_W-1:0] status;
  logic [REG_W-1:0] irq_mask;
  logic [REG_W-1:0] tx_data;
  logic [REG_W-1:0] rx_data;
  logic [REG_W-1:0] mode_reg;
  logic [REG_W-1:0] status_set;
  logic [REG_W-1:0] status_clr;
  logic [REG_W-1:0] tx_shift;
  logic [REG_W-1:0] rx_shift;
  logic [3:0] edge_cnt;
  logic [SYNC_W-1:0] pins_s;
  ssfec_state_e state;
  ssfec_state_e next_state;
  logic acc_done;
  logic sck_s;
  logic sdi_s;
  logic sub_s;
  logic sck_q;
  logic sub_q;
  logic sck_out;
  logic sdo;
  logic tx_active;
  logic rx_active;
  logic rx_halt;
  logic half_tick;
  logic ser_edge;
  logic is_first;
  logic latch_edge;
  logic start;
  logic wr_take;
  logic rd_take;
  logic tx_write_ok;
  logic ev_tx_load;
  logic ev_rx_store;
  logic ev_overrun;
  logic ev_tx_end;
  logic ev_conflict;

  // field views
  logic bit_order_select;
  logic clock_idle_polarity;
  logic clock_phase_select;
  logic [2:0] rate_select;
  logic tx_enable;
  logic rx_enable;
  logic rx_single_byte_stop;
  logic tx_end_irq_enable;
  logic tx_empty_irq_enable;
  logic rx_irq_enable;
  logic conflict_irq_enable;
  logic master;
  logic tx_empty_flag;
  logic rx_full_flag;
  logic overrun_flag;
  logic tx_end_flag;
  logic conflict_flag;

  assign bit_order_select = transfer_format_control[FMT_ORDER];
  assign clock_idle_polarity = transfer_format_control[FMT_POL];
  assign clock_phase_select = transfer_format_control[FMT_PHASE];
  assign rate_select = transfer_format_control[FMT_RATE_HI:FMT_RATE_LO];
  assign tx_enable = transfer_and_irq_enable[EN_TX];
  assign rx_enable = transfer_and_irq_enable[EN_RX];
  assign rx_single_byte_stop = transfer_and_irq_enable[EN_SSTOP];
  assign tx_end_irq_enable = transfer_and_irq_enable[EN_TX_END_IRQ_ENABLE];
  assign tx_empty_irq_enable = transfer_and_irq_enable[EN_TIE];
  assign rx_irq_enable = transfer_and_irq_enable[EN_RIE];
  assign conflict_irq_enable = transfer_and_irq_enable[EN_CONFLICT_IRQ_ENABLE];
  assign master = mode_reg[MODE_MASTER];
  assign tx_empty_flag = status[SB_TXEMPTY];
  assign rx_full_flag = status[SB_RXFULL];
  assign overrun_flag = status[SB_OVERRUN];
  assign tx_end_flag = status[SB_TXEND];
  assign conflict_flag = status[SB_CONFLICT];

  // ----------------------------------------------------------------
  // bit order helpers
  // ----------------------------------------------------------------
  function automatic logic out_bit(input logic [REG_W-1:0] sh, input logic msb_first);
    return msb_first ? sh[REG_W-1] : sh[0]; // R1
  endfunction : out_bit

  function automatic logic [REG_W-1:0] shift_out(input logic [REG_W-1:0] sh, input logic msb_first);
    return msb_first ? {sh[REG_W-2:0], 1'b0} : {1'b0, sh[REG_W-1:1]}; // R1
  endfunction : shift_out

  function automatic logic [REG_W-1:0] shift_in(input logic [REG_W-1:0] sh, input logic msb_first,
                                               input logic d);
    return msb_first ? {sh[REG_W-2:0], d} : {d, sh[REG_W-1:1]}; // R1
  endfunction : shift_in

  // ----------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------
  ssfec_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .ce_i(CLK_EN_I),
    .d_i({SCK_I, SDI_I, SUB_CLK_I}),
    .q_o(pins_s)
  );

  assign sck_s = pins_s[2];
  assign sdi_s = pins_s[1];
  assign sub_s = pins_s[0];

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sck_q <= 1'b0;
      sub_q <= 1'b0;
    end else if (CLK_EN_I) begin
      sck_q <= sck_s;
      sub_q <= sub_s;
    end
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  ssfec_rate u_rate (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .ce_i(CLK_EN_I),
    .run_i(master && state == SM_RUN),
    .rate_i(rate_select),
    .sub_rise_i(sub_s & ~sub_q),
    .tick_o(half_tick)
  );

  // ----------------------------------------------------------------
  // avalon slave: one wait state on every access
  // ----------------------------------------------------------------
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~acc_done;
  assign wr_take = AVS_WRITE_I & acc_done & AVS_BYTEENABLE_I[0];
  assign rd_take = AVS_READ_I & acc_done;

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      acc_done <= 1'b0;
    end else if (CLK_EN_I) begin
      acc_done <= (AVS_READ_I | AVS_WRITE_I) & ~acc_done;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      AVS_READDATA_O <= '0;
    end else if (CLK_EN_I && AVS_READ_I && !acc_done) begin
      case (AVS_ADDRESS_I)
        OFS_FORMAT: AVS_READDATA_O <= DATA_W'(transfer_format_control & FMT_MASK); // R4
        OFS_ENABLE: AVS_READDATA_O <= DATA_W'(transfer_and_irq_enable & EN_MASK); // R14
        OFS_STATUS: AVS_READDATA_O <= DATA_W'(status & ST_MASK);
        OFS_MASK: AVS_READDATA_O <= DATA_W'(irq_mask & ST_MASK);
        OFS_TXDATA: AVS_READDATA_O <= DATA_W'(tx_data);
        OFS_RXDATA: AVS_READDATA_O <= DATA_W'(rx_data);
        OFS_MODE: AVS_READDATA_O <= DATA_W'(mode_reg & MODE_MASK);
        default: AVS_READDATA_O <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // format changes mid-byte take effect at once; software should change it only while idle
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      transfer_format_control <= REG_RESET; // R14
    end else if (CLK_EN_I && wr_take && AVS_ADDRESS_I == OFS_FORMAT) begin
      transfer_format_control <= AVS_WRITEDATA_I[REG_W-1:0] & FMT_MASK; // R4
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      transfer_and_irq_enable <= REG_RESET; // R14
    end else if (CLK_EN_I && wr_take && AVS_ADDRESS_I == OFS_ENABLE) begin
      transfer_and_irq_enable <= AVS_WRITEDATA_I[REG_W-1:0] & EN_MASK; // R14
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      irq_mask <= REG_RESET;
      mode_reg <= REG_RESET;
    end else if (CLK_EN_I && wr_take) begin
      if (AVS_ADDRESS_I == OFS_MASK) begin
        irq_mask <= AVS_WRITEDATA_I[REG_W-1:0] & ST_MASK;
      end
      if (AVS_ADDRESS_I == OFS_MODE) begin
        mode_reg <= AVS_WRITEDATA_I[REG_W-1:0] & MODE_MASK;
      end
    end
  end

  // a write while data is still pending is refused so the queued byte is never lost
  assign tx_write_ok = wr_take && AVS_ADDRESS_I == OFS_TXDATA && tx_empty_flag;
  assign ev_conflict = wr_take && AVS_ADDRESS_I == OFS_TXDATA && !tx_empty_flag;

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      tx_data <= REG_RESET;
    end else if (CLK_EN_I && tx_write_ok) begin
      tx_data <= AVS_WRITEDATA_I[REG_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  assign start = !overrun_flag && (master ? (tx_enable ? (!tx_empty_flag)
                                                     : (rx_enable && !rx_full_flag && !rx_halt))
                                          : ((tx_enable && !tx_empty_flag) ||
                                             (rx_enable && !rx_halt))); // R7 R8 R9
  assign ser_edge = master ? half_tick : (sck_s ^ sck_q);
  assign is_first = ~edge_cnt[0];
  assign latch_edge = (is_first == clock_phase_select); // R3
  assign ev_tx_load = (state == SM_IDLE) && start && tx_enable && !tx_empty_flag; // R7

  always_comb begin
    next_state = state;
    case (state)
      SM_IDLE: begin
        if (start) begin
          next_state = SM_RUN;
        end
      end
      SM_RUN: begin
        if (ser_edge && edge_cnt == LAST_EDGE) begin
          next_state = SM_DONE;
        end
      end
      SM_DONE: next_state = SM_IDLE;
      default: next_state = SM_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state <= SM_IDLE;
    end else if (CLK_EN_I) begin
      state <= next_state;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      edge_cnt <= '0;
    end else if (CLK_EN_I) begin
      if (state != SM_RUN) begin
        edge_cnt <= '0;
      end else if (ser_edge) begin
        edge_cnt <= 4'(edge_cnt + 4'h1);
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      tx_active <= 1'b0;
      rx_active <= 1'b0;
    end else if (CLK_EN_I && state == SM_IDLE && start) begin
      tx_active <= ev_tx_load; // R7
      rx_active <= rx_enable && !rx_halt; // R8
    end
  end

  // serial clock: idle level from polarity, toggled by the prescaler in master mode
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sck_out <= 1'b1;
    end else if (CLK_EN_I) begin
      if (state != SM_RUN) begin
        sck_out <= ~clock_idle_polarity; // R2
      end else if (half_tick) begin
        sck_out <= ~sck_out;
      end
    end
  end

  // transmit side: phase 1 presents the first bit before the first edge
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      tx_shift <= REG_RESET;
      sdo <= 1'b1;
    end else if (CLK_EN_I) begin
      if (ev_tx_load) begin
        tx_shift <= tx_data;
        sdo <= clock_phase_select ? out_bit(tx_data, bit_order_select) : 1'b1; // R3
      end else if (state == SM_RUN && ser_edge && !latch_edge && tx_active) begin
        if (clock_phase_select) begin
          tx_shift <= shift_out(tx_shift, bit_order_select);
          sdo <= out_bit(shift_out(tx_shift, bit_order_select), bit_order_select); // R3
        end else begin
          tx_shift <= shift_out(tx_shift, bit_order_select);
          sdo <= out_bit(tx_shift, bit_order_select); // R3
        end
      end else if (state == SM_IDLE) begin
        sdo <= 1'b1;
      end
    end
  end

  // receive side: data pin is two cycles late, like the clock pin, and is read on the latch edge itself
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rx_shift <= REG_RESET;
    end else if (CLK_EN_I && state == SM_RUN && ser_edge && latch_edge && rx_active) begin
      rx_shift <= shift_in(rx_shift, bit_order_select, sdi_s); // R3 R8
    end
  end

  assign ev_rx_store = (state == SM_DONE) && rx_active && !rx_full_flag;
  assign ev_overrun = (state == SM_DONE) && rx_active && rx_full_flag; // R15
  assign ev_tx_end = (state == SM_DONE) && tx_active && tx_empty_flag; // R16

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rx_data <= REG_RESET;
    end else if (CLK_EN_I && ev_rx_store) begin
      rx_data <= rx_shift; // R15
    end
  end

  // single-byte stop holds reception until the enable register is written again
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rx_halt <= 1'b0;
    end else if (CLK_EN_I) begin
      if (state == SM_DONE && rx_active && rx_single_byte_stop) begin
        rx_halt <= 1'b1; // R9
      end else if (wr_take && AVS_ADDRESS_I == OFS_ENABLE) begin
        rx_halt <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags: set wins over clear
  // ----------------------------------------------------------------
  always_comb begin
    status_set = '0;
    status_set[SB_OVERRUN] = ev_overrun; // R15
    status_set[SB_TXEND] = ev_tx_end; // R16
    status_set[SB_TXEMPTY] = ev_tx_load;
    status_set[SB_RXFULL] = ev_rx_store;
    status_set[SB_CONFLICT] = ev_conflict;
    status_clr = '0;
    if (wr_take && AVS_ADDRESS_I == OFS_STATUS) begin
      status_clr = AVS_WRITEDATA_I[REG_W-1:0] & ST_W1C;
    end
    if (tx_write_ok) begin
      status_clr[SB_TXEMPTY] = 1'b1;
      status_clr[SB_TXEND] = 1'b1;
    end
    if (rd_take && AVS_ADDRESS_I == OFS_RXDATA) begin
      status_clr[SB_RXFULL] = 1'b1;
    end
  end

  for (genvar i = 0; i < REG_W; i++) begin : g_status
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
        status[i] <= ST_RESET[i];
      end else if (CLK_EN_I) begin
        status[i] <= status_set[i] | (status[i] & ~status_clr[i]);
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      TX_END_IRQ_O <= 1'b0;
      TX_DATA_IRQ_O <= 1'b0;
      RX_DATA_IRQ_O <= 1'b0;
      OVERRUN_IRQ_O <= 1'b0;
      CONFLICT_IRQ_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else if (CLK_EN_I) begin
      TX_END_IRQ_O <= tx_end_flag & tx_end_irq_enable; // R10 R17
      TX_DATA_IRQ_O <= tx_empty_flag & tx_empty_irq_enable; // R11 R17
      RX_DATA_IRQ_O <= rx_full_flag & rx_irq_enable; // R12 R17
      OVERRUN_IRQ_O <= overrun_flag & rx_irq_enable; // R12 R17
      CONFLICT_IRQ_O <= conflict_flag & conflict_irq_enable; // R13 R17
      IRQ_O <= |(status & irq_mask & ST_MASK);
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign SCK_O = sck_out; // R2
  assign SCK_OE_N_O = ~master;
  assign SDO_O = sdo;

endmodule : ssfec_top
`default_nettype wire

// File: hdl/ssfec_pkg.sv
// constants, register map and state type of the sync serial format and enable control
//
// Contract
// (R1) The bit order field set to 0 shifts the least significant bit first, set to 1 the most significant bit first.
// (R2) The serial clock idles high when the idle polarity field is 0 and low when it is 1.
// (R3) With clock phase 0 data changes on the first clock edge of each bit, with phase 1 data is latched on it.
// (R4) The two unused bits of the transfer format register always read as zero.
// (R5) The rate field picks system/256, /64, /16, /8, /4 or sub-clock/2 for codes 000, 010, 100, 101, 110, 111.
// (R6) Software selects the sub-clock/2 rate before entering the low-power modes where the system clock stops.
// (R7) Transmission happens only while the transmit enable field is 1.
// (R8) Reception happens only while the receive enable field is 1.
// (R9) With single-byte receive stop set, reception ends after one byte.
// (R10) The transmit-end request is issued only while its enable field is 1.
// (R11) The transmit-data-empty request is issued only while its enable field is 1.
// (R12) The one receive enable field gates both the receive-data-full and the overrun request.
// (R13) The conflict request is issued only while its enable field is 1.
// (R14) The unused bit of the enable register reads as zero and all fields of both registers reset to zero.
// (R15) A reception that completes while receive data is still full sets overrun, keeps the old byte, drops the new.
// (R16) The transmit-end flag is set when the last bit has gone out and transmit data is empty.
// (R17) Each request output is high exactly while its condition holds and its enable field is 1; the code registers each one, so it follows one cycle late.
package ssfec_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int ADDR_W = 5;
  localparam int BE_W = 4;
  localparam int SYNC_W = 3;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_FORMAT = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_MASK = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_TXDATA = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_RXDATA = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_MODE = 5'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FMT_ORDER = 7;
  localparam int FMT_POL = 6;
  localparam int FMT_PHASE = 5;
  localparam int FMT_RATE_HI = 2;
  localparam int FMT_RATE_LO = 0;
  localparam int EN_TX = 7;
  localparam int EN_RX = 6;
  localparam int EN_SSTOP = 5;
  localparam int EN_TX_END_IRQ_ENABLE = 3;
  localparam int EN_TIE = 2;
  localparam int EN_RIE = 1;
  localparam int EN_CONFLICT_IRQ_ENABLE = 0;
  localparam int SB_OVERRUN = 6;
  localparam int SB_TXEND = 3;
  localparam int SB_TXEMPTY = 2;
  localparam int SB_RXFULL = 1;
  localparam int SB_CONFLICT = 0;
  localparam int MODE_MASTER = 0;

  // ----------------------------------------------------------------
  // masks and reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] FMT_MASK = 8'he7;
  localparam logic [REG_W-1:0] EN_MASK = 8'hef;
  localparam logic [REG_W-1:0] ST_MASK = 8'h4f;
  localparam logic [REG_W-1:0] ST_W1C = 8'h49;
  localparam logic [REG_W-1:0] MODE_MASK = 8'h01;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  localparam logic [REG_W-1:0] ST_RESET = 8'h04;

  // ----------------------------------------------------------------
  // rate codes and half-period terminal counts
  // ----------------------------------------------------------------
  localparam logic [2:0] RATE_DIV256 = 3'h0;
  localparam logic [2:0] RATE_DIV64 = 3'h2;
  localparam logic [2:0] RATE_DIV16 = 3'h4;
  localparam logic [2:0] RATE_DIV8 = 3'h5;
  localparam logic [2:0] RATE_DIV4 = 3'h6;
  localparam logic [2:0] RATE_SUB2 = 3'h7;
  localparam logic [7:0] HALF_DIV256 = 8'h7f;
  localparam logic [7:0] HALF_DIV64 = 8'h1f;
  localparam logic [7:0] HALF_DIV16 = 8'h07;
  localparam logic [7:0] HALF_DIV8 = 8'h03;
  localparam logic [7:0] HALF_DIV4 = 8'h01;
  localparam logic [3:0] LAST_EDGE = 4'hf;

  typedef enum logic [1:0] {
    SM_IDLE = 2'b00,
    SM_RUN = 2'b01,
    SM_DONE = 2'b10
  } ssfec_state_e;

endpackage : ssfec_pkg

// File: hdl/ssfec_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module ssfec_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else if (ce_i) begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : ssfec_sync
`default_nettype wire

// File: hdl/ssfec_rate.sv
// transfer clock prescaler, one tick per serial clock half period
`timescale 1ns/100ps
`default_nettype none
module ssfec_rate
  import ssfec_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // control
  input wire logic run_i,
  input wire logic [2:0] rate_i,
  input wire logic sub_rise_i,
  // tick
  output logic tick_o
);
  logic [7:0] cnt;
  logic [7:0] terminal;

  always_comb begin
    case (rate_i) // R5
      RATE_DIV64: terminal = HALF_DIV64;
      RATE_DIV16: terminal = HALF_DIV16;
      RATE_DIV8: terminal = HALF_DIV8;
      RATE_DIV4: terminal = HALF_DIV4;
      // undefined codes fall back to the slowest rate rather than hang a transfer
      default: terminal = HALF_DIV256;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else if (ce_i) begin
      if (!run_i || cnt == terminal) begin
        cnt <= '0;
      end else begin
        cnt <= 8'(cnt + 8'h01);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (rate_i == RATE_SUB2) begin
        tick_o <= run_i & sub_rise_i; // R5
      end else begin
        tick_o <= run_i & (cnt == terminal); // R5
      end
    end
  end
endmodule : ssfec_rate
`default_nettype wire

// File: verif/ssfec_chk.sv
// checker of register read-back and interrupt gating
`timescale 1ns/100ps
`default_nettype none
module ssfec_chk
  import ssfec_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  // register bus
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [BE_W-1:0] AVS_BYTEENABLE_I,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA_I,
  input wire logic [DATA_W-1:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  // pins and requests
  input wire logic SDO_O,
  input wire logic TX_END_IRQ_O,
  input wire logic TX_DATA_IRQ_O,
  input wire logic RX_DATA_IRQ_O,
  input wire logic OVERRUN_IRQ_O,
  input wire logic CONFLICT_IRQ_O
);
  // shadow of the enable register, so gating is judged from the bus alone
  logic [REG_W-1:0] en_sh;
  wire logic rd_ok = AVS_READ_I && !AVS_WAITREQUEST_O;
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) en_sh <= REG_RESET;
    else if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0] &&
             AVS_ADDRESS_I == OFS_ENABLE) en_sh <= AVS_WRITEDATA_I[REG_W-1:0] & EN_MASK;
  end
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  chk_fmt_rsvd: assert property (
    rd_ok && AVS_ADDRESS_I == OFS_FORMAT |-> AVS_READDATA_O[4:3] == 2'h0)
    else $error("format spare bits read one");
  chk_en_rsvd: assert property (
    rd_ok && AVS_ADDRESS_I == OFS_ENABLE |-> !AVS_READDATA_O[4])
    else $error("enable spare bit read one");
  chk_tx_end_flag_gate: assert property (TX_END_IRQ_O |-> $past(en_sh[EN_TX_END_IRQ_ENABLE]))
    else $error("tx end request while disabled");
  chk_txe_gate: assert property (TX_DATA_IRQ_O |-> $past(en_sh[EN_TIE]))
    else $error("tx data request while disabled");
  chk_rxf_gate: assert property (RX_DATA_IRQ_O |-> $past(en_sh[EN_RIE]))
    else $error("rx data request while disabled");
  chk_ovr_gate: assert property (OVERRUN_IRQ_O |-> $past(en_sh[EN_RIE]))
    else $error("overrun request while disabled");
  chk_cfl_gate: assert property (CONFLICT_IRQ_O |-> $past(en_sh[EN_CONFLICT_IRQ_ENABLE]))
    else $error("conflict request while disabled");
  chk_tx_gate: assert property (!$stable(SDO_O) |-> $past(en_sh[EN_TX]))
    else $error("data out moved with transmit off");
endmodule : ssfec_chk
bind ssfec_top ssfec_chk ssfec_chk_i (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
  .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .SDO_O(SDO_O),
  .TX_END_IRQ_O(TX_END_IRQ_O), .TX_DATA_IRQ_O(TX_DATA_IRQ_O), .RX_DATA_IRQ_O(RX_DATA_IRQ_O),
  .OVERRUN_IRQ_O(OVERRUN_IRQ_O), .CONFLICT_IRQ_O(CONFLICT_IRQ_O));
`default_nettype wire

// File: verif/ssfec_peer.sv
// serial peer: shifts a byte out msb first, captures the data line
`timescale 1ns/100ps
`default_nettype none
module ssfec_peer #(
  parameter logic [7:0] PEER_BYTE = 8'h3c
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic sdo_i,
  output logic sdi_o,
  output logic [7:0] got_o
);
  logic sck_q;
  logic [7:0] out;
  // refill with the complement so consecutive bytes differ
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_q <= 1'b1;
      sdi_o <= 1'b0;
      got_o <= 8'h00;
      out <= PEER_BYTE;
    end else begin
      sck_q <= sck_i;
      if (sck_q && !sck_i) begin
        sdi_o <= out[7];
        out <= {out[6:0], ~out[7]};
      end
      if (!sck_q && sck_i) got_o <= {got_o[6:0], sdo_i};
    end
  end
endmodule : ssfec_peer
`default_nettype wire

// File: verif/tb.sv
// self-checking bench of the sync serial format and enable control
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected %0t got %h want %h", $time, (a), (e)); end end
module tb;
  import ssfec_pkg::*;
  logic clk, rst, rd, wr, sub, sdi, wreq, irq, tx_end_irq, tx_data_irq, rx_data_irq, overrun_irq, conflict_irq, sck, sdo;
  logic [ADDR_W-1:0] addr;
  logic [BE_W-1:0] be;
  logic [DATA_W-1:0] wdata, rdata;
  logic [7:0] q, got;
  logic [1:0] sc;
  int err_count, n_compared;
  ssfec_top ssfec_top_i (.SYS_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(1'b1),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be),
    .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq),
    .SCK_I(sck), .SCK_O(sck), .SCK_OE_N_O(), .SDI_I(sdi), .SDO_O(sdo), .SUB_CLK_I(sub),
    .IRQ_O(irq), .TX_END_IRQ_O(tx_end_irq), .TX_DATA_IRQ_O(tx_data_irq), .RX_DATA_IRQ_O(rx_data_irq),
    .OVERRUN_IRQ_O(overrun_irq), .CONFLICT_IRQ_O(conflict_irq));
  ssfec_peer ssfec_peer_i (.clk_i(clk), .rst_i(rst), .sck_i(sck), .sdo_i(sdo),
    .sdi_o(sdi), .got_o(got));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // sub-clock of 160 ns
  always @(posedge clk) begin
    sc <= sc + 2'h1;
    if (sc == 2'h3) sub <= ~sub;
  end
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc
  task automatic wait_end;
    q = 8'h00;
    while (q[SB_TXEND] !== 1'b1) acc(1'b0, OFS_STATUS, 8'h00);
  endtask : wait_end
  task automatic conclude;
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    conclude();
  end
  initial begin
    {rst, rd, wr, addr, wdata, sub, sc, err_count, n_compared} = '0;
    rst = 1'b1;
    be = 4'hf;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, OFS_FORMAT, 8'h00); `CHK(q, REG_RESET)
    acc(1'b0, OFS_ENABLE, 8'h00); `CHK(q, REG_RESET)
    acc(1'b1, OFS_FORMAT, 8'hff); acc(1'b0, OFS_FORMAT, 8'h00); `CHK(q, FMT_MASK)
    acc(1'b1, OFS_MODE, 8'h01); // master and nothing queued: no start
    acc(1'b1, OFS_ENABLE, 8'hff); acc(1'b0, OFS_ENABLE, 8'h00); `CHK(q, EN_MASK)
    `CHK(tx_data_irq, 1'b1)
    acc(1'b1, OFS_ENABLE, 8'h01); acc(1'b1, OFS_FORMAT, 8'h85); `CHK(tx_data_irq, 1'b0)
    acc(1'b1, OFS_MASK, 8'h08);
    acc(1'b1, OFS_TXDATA, 8'h11);
    acc(1'b1, OFS_TXDATA, 8'h22); acc(1'b0, OFS_STATUS, 8'h00); `CHK(conflict_irq, 1'b1)
    acc(1'b1, OFS_ENABLE, 8'hca); acc(1'b1, OFS_STATUS, 8'h01); `CHK(conflict_irq, 1'b0)
    wait_end(); `CHK(got, 8'h11)
    `CHK(tx_end_irq, 1'b1)
    `CHK(irq, 1'b1)
    acc(1'b1, OFS_STATUS, 8'h08); acc(1'b1, OFS_FORMAT, 8'h07); `CHK(irq, 1'b0)
    `CHK(rx_data_irq, 1'b1)
    acc(1'b1, OFS_TXDATA, 8'h11);
    wait_end(); `CHK(got, 8'h88)
    `CHK(overrun_irq, 1'b1)
    // the format read-back write of ff set polarity 1 and made one idle fall, shifting the peer byte once with its complement refill
    acc(1'b0, OFS_RXDATA, 8'h00); `CHK(q, 8'h79)
    conclude();
  end
endmodule : tb
`default_nettype wire
